// ==== host_irq_line_control.sv ====
// Host interrupt line control: APB registers, buffer-full flags and three host IRQ lines.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module host_irq_line_control
  import host_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_km_read,
  input wire logic host_pm_read,
  output logic irq_kbd,
  output logic irq_mouse,
  output logic irq_pm,
  output logic [7:0] host_out_buffer,
  output logic [7:0] pm_out_buffer,
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_LINE_CTRL = {IDX_LINE_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_KBD_DATA = {IDX_KBD_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_MOUSE_DATA = {IDX_MOUSE_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_CHAN_CTRL = {IDX_CHAN_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_PM_DATA = {IDX_PM_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_FLAGS = {IDX_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] A_INT_STATUS = {IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] A_INT_MASK = {IDX_INT_MASK, 2'b00};

  logic [7:0] line_ctrl_r;
  logic [7:0] chan_ctrl_r;
  logic km_full_r;
  logic km_owner_mouse_r;
  logic pm_full_r;
  logic [NUM_EVENTS-1:0] int_status_r;
  logic [NUM_EVENTS-1:0] int_mask_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic setup;
  logic wr_commit;
  logic hit;
  logic wr_line_ctrl;
  logic wr_kbd;
  logic wr_mouse;
  logic wr_pm;
  logic [NUM_LINES-1:0] lines;
  logic [NUM_LINES-1:0] hw_en;
  logic [NUM_LINES-1:0] full_flag;
  logic [NUM_LINES-1:0] trigger;
  logic [NUM_EVENTS-1:0] events;
  logic [31:0] rd_mux;
  line_shape_s shape;

  // Setup phase latches read data, so the access phase answers at once
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign wr_commit = psel && penable && pwrite;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && pready;

  assign wr_line_ctrl = wr_commit && paddr == A_LINE_CTRL;
  assign wr_kbd = wr_commit && paddr == A_KBD_DATA;
  assign wr_mouse = wr_commit && paddr == A_MOUSE_DATA;
  assign wr_pm = wr_commit && paddr == A_PM_DATA;

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      A_LINE_CTRL: rd_mux = {24'h000000, 1'b0, line_ctrl_r[6:3], lines};
      A_KBD_DATA: rd_mux = '0;
      A_MOUSE_DATA: rd_mux = '0;
      A_CHAN_CTRL: rd_mux = {24'h000000, chan_ctrl_r};
      A_PM_DATA: rd_mux = '0;
      A_FLAGS: rd_mux = {29'h00000000, pm_full_r, km_owner_mouse_r, km_full_r};
      A_INT_STATUS: rd_mux = {30'h00000000, int_status_r};
      A_INT_MASK: rd_mux = {30'h00000000, int_mask_r};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_r <= !hit;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ctrl_r <= LINE_CTRL_RESET;
    end else if (wr_line_ctrl) begin
      line_ctrl_r <= pwdata[7:0] & LINE_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ctrl_r <= CHAN_CTRL_RESET;
    end else if (wr_commit && paddr == A_CHAN_CTRL) begin
      chan_ctrl_r <= pwdata[7:0] & CHAN_CTRL_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_r <= '0;
    end else if (wr_commit && paddr == A_INT_MASK) begin
      int_mask_r <= pwdata[NUM_EVENTS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Output buffers and full flags
  // ----------------------------------------------------------------
  // Keyboard and mouse share one buffer; the owner bit steers the level line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_out_buffer <= '0;
      km_owner_mouse_r <= 1'b0;
    end else if (wr_kbd || wr_mouse) begin
      host_out_buffer <= pwdata[7:0];
      km_owner_mouse_r <= wr_mouse;
    end
  end

  // A write in the same cycle as the host read wins, so new data is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      km_full_r <= 1'b0;
    end else if (wr_kbd || wr_mouse) begin
      km_full_r <= 1'b1;
    end else if (host_km_read) begin
      km_full_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_out_buffer <= '0;
      pm_full_r <= 1'b0;
    end else if (wr_pm) begin
      pm_out_buffer <= pwdata[7:0];
      pm_full_r <= 1'b1;
    end else if (host_pm_read) begin
      pm_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt lines
  // ----------------------------------------------------------------
  assign shape = {line_ctrl_r[LC_INV_BIT], line_ctrl_r[LC_SHAPE_LSB +: 3]};

  assign hw_en[LINE_KBD] = chan_ctrl_r[CC_KBD_EN];
  assign hw_en[LINE_MOUSE] = chan_ctrl_r[CC_MOUSE_EN];
  assign hw_en[LINE_PM] = chan_ctrl_r[CC_COMPAT] && chan_ctrl_r[CC_PM_EN];
  assign full_flag[LINE_KBD] = km_full_r && !km_owner_mouse_r;
  assign full_flag[LINE_MOUSE] = km_full_r && km_owner_mouse_r;
  assign full_flag[LINE_PM] = pm_full_r;
  assign trigger[LINE_KBD] = wr_kbd;
  assign trigger[LINE_MOUSE] = wr_mouse;
  assign trigger[LINE_PM] = wr_pm;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
      irq_line_gen u_line (
        .pclk(pclk),
        .presetn(presetn),
        .direct_val(line_ctrl_r[LC_DIRECT_LSB + gi]),
        .hw_en(hw_en[gi]),
        .shape(shape),
        .full_flag(full_flag[gi]),
        .trigger(trigger[gi]),
        .line_r(lines[gi])
      );
    end
  endgenerate

  assign irq_kbd = lines[LINE_KBD];
  assign irq_mouse = lines[LINE_MOUSE];
  assign irq_pm = lines[LINE_PM];

  // ----------------------------------------------------------------
  // Core interrupt: buffer drained by the host
  // ----------------------------------------------------------------
  assign events[EV_KM_EMPTY] = host_km_read && km_full_r && !(wr_kbd || wr_mouse);
  assign events[EV_PM_EMPTY] = host_pm_read && pm_full_r && !wr_pm;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= events |
        (int_status_r & ~((wr_commit && paddr == A_INT_STATUS) ? pwdata[NUM_EVENTS-1:0] : '0));
    end
  end

  assign irq = |(int_status_r & int_mask_r);

endmodule

// ==== host_irq_pkg.sv ====
// Constants, register map and types shared by the host interrupt line control block.
//
// Operation
// - Reset loads the line control register with 07 hex.
// - Keyboard enable clear: IRQ1 follows line control bit 0.
// - Reading bit 0 returns the present IRQ1 pin level.
// - Mouse enable clear: IRQ12 follows line control bit 1.
// - Reading bit 1 returns the present IRQ12 level.
// - Legacy mode with PM enable clear: IRQ11 follows bit 2.
// - Reading bit 2 returns the present IRQ11 level.
// - Shape field zero: hardware lines are level interrupts.
// - Level mode, normal polarity: idle low, high while buffer full.
// - Nonzero shape: pulse mode, idle high, low pulse per buffer write.
// - Shape codes 1..5 give pulses of 1, 2, 4, 8, 16 cycles.
// - Invert bit set inverts every hardware-controlled line.
// - Bit 7 is reserved and has no effect.
// - Keyboard enable set: keyboard data write triggers IRQ1.
// - Mouse enable set: mouse data write triggers IRQ12.
// - Host read of the output buffer clears the full flag.
package host_irq_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_LINE_CTRL = 16'hfea2;
  localparam logic [15:0] IDX_KBD_DATA = 16'hfea6;
  localparam logic [15:0] IDX_MOUSE_DATA = 16'hfea8;
  localparam logic [15:0] IDX_CHAN_CTRL = 16'hfeb0;
  localparam logic [15:0] IDX_PM_DATA = 16'hfeb2;
  localparam logic [15:0] IDX_FLAGS = 16'hfeb4;
  localparam logic [15:0] IDX_INT_STATUS = 16'hfeb6;
  localparam logic [15:0] IDX_INT_MASK = 16'hfeb8;
  localparam int ADDR_W = 18;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_CTRL_RESET = 8'h07;
  localparam logic [7:0] LINE_CTRL_WMASK = 8'h7f;
  localparam int LC_DIRECT_LSB = 0;
  localparam int LC_SHAPE_LSB = 3;
  localparam int LC_INV_BIT = 6;
  localparam int CC_KBD_EN = 0;
  localparam int CC_MOUSE_EN = 1;
  localparam int CC_PM_EN = 4;
  localparam int CC_COMPAT = 7;
  localparam logic [7:0] CHAN_CTRL_RESET = 8'h80;
  localparam logic [7:0] CHAN_CTRL_WMASK = 8'h93;
  localparam int NUM_LINES = 3;
  localparam int LINE_KBD = 0;
  localparam int LINE_MOUSE = 1;
  localparam int LINE_PM = 2;
  localparam int NUM_EVENTS = 2;
  localparam int EV_KM_EMPTY = 0;
  localparam int EV_PM_EMPTY = 1;

  // ----------------------------------------------------------------
  // Pulse shaping
  // ----------------------------------------------------------------
  localparam int PULSE_CNT_W = 5;
  localparam logic [2:0] SHAPE_LEVEL = 3'h0;

  typedef struct packed {
    logic inv;
    logic [2:0] shape;
  } line_shape_s;

  // Reserved codes fall back to the longest pulse so a line never sticks
  function automatic logic [PULSE_CNT_W-1:0] pulse_len(input logic [2:0] code);
    case (code)
      3'h1: pulse_len = 5'h01;
      3'h2: pulse_len = 5'h02;
      3'h3: pulse_len = 5'h04;
      3'h4: pulse_len = 5'h08;
      default: pulse_len = 5'h10;
    endcase
  endfunction

endpackage

// ==== host_model.sv ====
// Host side model: reads the keyboard/mouse output buffer on command
`timescale 1ns/100ps
module host_model (
  input wire logic pclk,
  input wire logic km_req,
  input wire logic [3:0] lag,
  input wire logic [7:0] host_out_buffer,
  output logic host_km_read,
  output logic [7:0] km_seen
);
  initial begin
    host_km_read = 1'b0;
    km_seen = 8'h00;
  end
  // A slow host answers after lag clocks; the read strobe lasts one clock
  always @(posedge pclk) begin
    if (km_req) begin
      repeat (lag) @(posedge pclk);
      host_km_read <= 1'b1;
      km_seen <= host_out_buffer;
    end else begin
      host_km_read <= 1'b0;
    end
  end
endmodule

// ==== irq_chk.sv ====
// Assertion checker for the host IRQ line control ports
`timescale 1ns/100ps
module irq_chk
  import host_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic irq_kbd,
  input wire logic irq_mouse,
  input wire logic irq_pm
);
  localparam logic [ADDR_W-1:0] A_LC = {IDX_LINE_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_CC = {IDX_CHAN_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_KD = {IDX_KBD_DATA, 2'b00};
  logic [7:0] lc_r;
  logic [7:0] cc_r;
  logic wr;
  logic kw;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pwrite;
  assign kw = wr && paddr == A_KD && cc_r[CC_KBD_EN];
  // Shadow control registers, so line levels can be tied to what firmware wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_r <= LINE_CTRL_RESET;
      cc_r <= CHAN_CTRL_RESET;
    end else if (wr) begin
      if (paddr == A_LC) lc_r <= pwdata[7:0] & LINE_CTRL_WMASK;
      if (paddr == A_CC) cc_r <= pwdata[7:0] & CHAN_CTRL_WMASK;
    end
  end
  property p_rst; $rose(presetn) |-> irq_kbd && irq_mouse && irq_pm; endproperty
  a_rst: assert property (p_rst) else $error("lines not high after reset");
  property p_kd; !$past(cc_r[CC_KBD_EN]) |-> irq_kbd == $past(lc_r[0]); endproperty
  a_kd: assert property (p_kd) else $error("kbd line not direct");
  property p_md; !$past(cc_r[CC_MOUSE_EN]) |-> irq_mouse == $past(lc_r[1]); endproperty
  a_md: assert property (p_md) else $error("mouse line not direct");
  property p_pd; !$past(cc_r[CC_COMPAT] && cc_r[CC_PM_EN]) |-> irq_pm == $past(lc_r[2]); endproperty
  a_pd: assert property (p_pd) else $error("pm line not direct");
  property p_rb; psel && penable && !pwrite && paddr == A_LC |->
    prdata[7:0] == {1'b0, $past(lc_r[6:3]), $past(irq_pm), $past(irq_mouse), $past(irq_kbd)}; endproperty
  a_rb: assert property (p_rb) else $error("line control readback");
  property p_p1; kw && lc_r[6:3] == 4'h1 |-> ##2 !irq_kbd ##1 irq_kbd; endproperty
  a_p1: assert property (p_p1) else $error("one cycle pulse");
  property p_p8; kw && lc_r[6:3] == 4'h4 |-> ##2 !irq_kbd [*8] ##1 irq_kbd; endproperty
  a_p8: assert property (p_p8) else $error("eight cycle pulse");
  property p_inv; kw && lc_r[6:3] == 4'h9 |-> ##2 irq_kbd ##1 !irq_kbd; endproperty
  a_inv: assert property (p_inv) else $error("inverted pulse");
  property p_lvl; kw && lc_r[6:3] == 4'h0 |-> ##2 irq_kbd; endproperty
  a_lvl: assert property (p_lvl) else $error("level not raised");
endmodule
bind host_irq_line_control irq_chk u_chk(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .irq_kbd, .irq_mouse, .irq_pm);

// ==== irq_line_gen.sv ====
// One host interrupt request line: direct, level or pulse drive.
`timescale 1ns/100ps
module irq_line_gen
  import host_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic direct_val,
  input wire logic hw_en,
  input wire line_shape_s shape,
  input wire logic full_flag,
  input wire logic trigger,
  output logic line_r
);

  logic [PULSE_CNT_W-1:0] cnt_r;
  logic std_level;
  logic line_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (trigger && hw_en && shape.shape != SHAPE_LEVEL) begin
      cnt_r <= pulse_len(shape.shape);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_comb begin
    if (shape.shape == SHAPE_LEVEL) begin
      std_level = full_flag;
    end else begin
      std_level = (cnt_r == '0);
    end
    if (hw_en) begin
      line_nxt = std_level ^ shape.inv;
    end else begin
      line_nxt = direct_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= 1'b1;
    end else begin
      line_r <= line_nxt;
    end
  end

endmodule

// ==== testbench.sv ====
// Self-checking bench for the host IRQ line control block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  import host_irq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_kbd, irq_mouse, irq_pm, irq, hkr, kq, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] hob, seen, pob;
  logic pmr;
  logic [3:0] lag;
  logic [2:0] ln;
  int bad_count, tests_run, n;
  int len[8] = '{0, 1, 2, 4, 8, 16, 16, 16};
  assign ln = {irq_pm, irq_mouse, irq_kbd};
  host_irq_line_control u_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .host_km_read(hkr), .host_pm_read(pmr), .irq_kbd, .irq_mouse, .irq_pm, .host_out_buffer(hob),
    .pm_out_buffer(pob), .irq);
  host_model u_host(.pclk, .km_req(kq), .lag, .host_out_buffer(hob), .host_km_read(hkr), .km_seen(seen));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic close_out();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic guard();
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    guard();
  endtask
  task automatic settle();
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic hread(input logic [3:0] l, input int k);
    lag <= l;
    kq <= 1'b1;
    @(posedge pclk);
    kq <= 1'b0;
    n = 0;
    while (ln[k] !== 1'b0 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    guard();
  endtask
  // Counts active cycles over a window longer than the widest pulse
  task automatic count(input int k, input logic act);
    n = 0;
    repeat (40) begin
      @(negedge pclk);
      if (ln[k] === act) n++;
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    kq = 1'b0;
    pmr = 1'b0;
    lag = 4'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(ln, 3'h7)
    xfer(1'b0, IDX_LINE_CTRL, 32'h0);
    `CHK(rd, 32'h07)
    xfer(1'b0, IDX_CHAN_CTRL, 32'h0);
    `CHK(rd, 32'h80)
    xfer(1'b0, 16'h0001, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, IDX_LINE_CTRL, 32'(8'h80 + i));
      settle();
      `CHK(ln, 3'(i))
      xfer(1'b0, IDX_LINE_CTRL, 32'h0);
      `CHK(rd, 32'(i))
    end
    xfer(1'b1, IDX_LINE_CTRL, 32'h0);
    xfer(1'b1, IDX_CHAN_CTRL, 32'h83);
    xfer(1'b1, IDX_INT_MASK, 32'h1);
    xfer(1'b1, IDX_KBD_DATA, 32'h5a);
    settle();
    `CHK({ln, hob}, 11'h15a)
    xfer(1'b0, IDX_LINE_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    hread(4'h3, 0);
    `CHK({ln, irq, seen}, 12'h15a)
    xfer(1'b1, IDX_INT_STATUS, 32'h1);
    xfer(1'b0, IDX_INT_STATUS, 32'h0);
    `CHK({irq, rd}, 33'h0)
    xfer(1'b1, IDX_INT_MASK, 32'h0);
    xfer(1'b1, IDX_MOUSE_DATA, 32'ha5);
    settle();
    `CHK(ln, 3'h2)
    hread(4'h0, 1);
    xfer(1'b0, IDX_INT_STATUS, 32'h0);
    `CHK({irq, rd}, 33'h1)
    xfer(1'b1, IDX_CHAN_CTRL, 32'h91);
    for (int c = 1; c < 8; c++) begin
      xfer(1'b1, IDX_LINE_CTRL, 32'(c * 8));
      xfer(1'b1, IDX_KBD_DATA, 32'(c));
      count(0, 1'b0);
      `CHK(n, len[c])
    end
    xfer(1'b1, IDX_LINE_CTRL, 32'h48);
    xfer(1'b1, IDX_KBD_DATA, 32'h1);
    count(0, 1'b1);
    `CHK(n, 1)
    xfer(1'b1, IDX_PM_DATA, 32'h2);
    count(2, 1'b1);
    `CHK(n, 1)
    `CHK(pob, 8'h02)
    xfer(1'b0, IDX_FLAGS, 32'h0);
    `CHK(rd, 32'h5)
    pmr <= 1'b1;
    @(posedge pclk);
    pmr <= 1'b0;
    xfer(1'b0, IDX_FLAGS, 32'h0);
    `CHK(rd, 32'h1)
    xfer(1'b0, IDX_INT_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    // Direct bit 2 set: legacy mode off must show it, not the inverted idle level
    xfer(1'b1, IDX_CHAN_CTRL, 32'h11);
    xfer(1'b1, IDX_LINE_CTRL, 32'h4c);
    settle();
    `CHK(ln, 3'h4)
    close_out();
  end
endmodule
